// ===== acm_dev.sv
// Purpose: Converter end: serial register port, power state, mode and input routing.
// Assumes: ref_clk_i is the sample clock; the serial clock runs only in frames.
// Notes: Serial logic runs on the link clock; registers on ref_clk_i.
// Notes on behaviour
// - Internal timing uses rising sample clock edges only.
// - No register selects the clock source format.
// - Host resets by pin pulse or soft write.
// - Host then powers down by pin or register.
// - Host sets bit clock phase only if needed.
// - Host writes mode and divider while powered down.
// - Host returns to active by pin or register.
// - Mode changes only while powered down.
// - Mode codes select single, dual or quad.
// - Input selections apply at each write completion.
// - Dual mode routes per channel from bytes.
// - Single mode takes channel one byte.
`timescale 1ns/100ps
`default_nettype none
module acm_dev
  import acm_pkg::*;
(
  // Sample clock domain
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Link
  acm_link_if.dev link,
  // Converter state
  output logic [1:0] mode_o,
  output logic [2:0] divider_o,
  output logic powered_down_o,
  output logic mode_reject_o,
  output logic sample_en_o,
  output logic [15:0] bit_clk_phase_o,
  output logic [7:0] ch_input_o,
  output logic [3:0] ch_valid_o
);
  // ----------------------------------------------------------------
  // Serial receive on the link clock
  // ----------------------------------------------------------------
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [23:0] shift_r, shift_nxt, word_r, word_nxt;
  logic frame_tgl_r, frame_tgl_nxt, frame_done;

  // Data is taken on the rising link edge only
  always_comb begin
    shift_nxt = {shift_r[22:0], link.sdata};
    frame_done = (bit_cnt_r == ACM_LAST_BIT);
    bit_cnt_nxt = frame_done ? 5'h00 : bit_cnt_r + 5'h01;
    word_nxt = frame_done ? shift_nxt : word_r;
    frame_tgl_nxt = frame_done ? ~frame_tgl_r : frame_tgl_r;
  end

  // Chip select high clears the bit count, so a cut frame is dropped
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 24'h000000;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
    end
  end

  // Word holds until the next complete frame, long after it is absorbed
  always_ff @(posedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_r <= 24'h000000;
      frame_tgl_r <= 1'b0;
    end else begin
      word_r <= word_nxt;
      frame_tgl_r <= frame_tgl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the sample clock domain
  // ----------------------------------------------------------------
  // Bit 0 frame toggle, bit 1 reset pin, bit 2 power-down pin
  logic [2:0] raw_in, s1_r, s2_r, s3_r, flt_r, flt_nxt;
  localparam logic [2:0] SYNC_RST = 3'h2;

  assign raw_in = {link.power_down_pin, link.chip_reset_low, frame_tgl_r};

  // A change counts only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flt
      assign flt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : flt_r[gi];
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
      flt_r <= SYNC_RST;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic seen_r, seen_nxt, new_word, reject_r, reject_nxt, pd_eff, mode_ok, do_reset;
  logic [7:0] wr_addr;
  logic [15:0] wr_data, power_r, power_nxt, mode_r, mode_nxt, sel12_r, sel12_nxt;
  logic [15:0] sel34_r, sel34_nxt, phase_r, phase_nxt;

  assign new_word = (flt_r[0] != seen_r);
  assign wr_addr = word_r[23:16];
  assign wr_data = word_r[15:0];
  assign pd_eff = power_r[ACM_POWER_DOWN_BIT] | flt_r[2];
  // The word register is stable here: the toggle was seen after it settled
  assign mode_ok = (wr_data == ACM_MODE_SINGLE_VAL) || (wr_data == ACM_MODE_DUAL_VAL) ||
                   (wr_data == ACM_MODE_QUAD_VAL);

  // Writes land when a completed frame is seen in this domain
  always_comb begin
    seen_nxt = flt_r[0];
    power_nxt = power_r;
    mode_nxt = mode_r;
    sel12_nxt = sel12_r;
    sel34_nxt = sel34_r;
    phase_nxt = phase_r;
    reject_nxt = reject_r;
    do_reset = !flt_r[1];
    if (new_word) begin
      case (wr_addr)
        ACM_REG_SOFT_RESET: do_reset = do_reset | (wr_data == ACM_SOFT_RESET_CMD);
        ACM_REG_POWER: power_nxt = wr_data;
        ACM_REG_MODE: begin
          // Synchronisation needs power down; a mode write while active is dropped
          if (pd_eff && mode_ok) begin
            mode_nxt = wr_data;
            reject_nxt = 1'b0;
          end else begin
            reject_nxt = 1'b1;
          end
        end
        ACM_REG_SEL_12: sel12_nxt = wr_data;
        ACM_REG_SEL_34: sel34_nxt = wr_data;
        ACM_REG_PHASE: phase_nxt = wr_data;
        default: power_nxt = power_r;
      endcase
    end
    if (do_reset) begin
      power_nxt = ACM_POWER_RST;
      mode_nxt = ACM_MODE_RST;
      sel12_nxt = ACM_SEL_RST;
      sel34_nxt = ACM_SEL_RST;
      phase_nxt = ACM_PHASE_RST;
      reject_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {seen_r, reject_r, power_r, mode_r} <= {2'b00, ACM_POWER_RST, ACM_MODE_RST};
      {sel12_r, sel34_r, phase_r} <= {ACM_SEL_RST, ACM_SEL_RST, ACM_PHASE_RST};
    end else begin
      {seen_r, reject_r, power_r, mode_r} <= {seen_nxt, reject_nxt, power_nxt, mode_nxt};
      {sel12_r, sel34_r, phase_r} <= {sel12_nxt, sel34_nxt, phase_nxt};
    end
  end

  // ----------------------------------------------------------------
  // Mode decode, divider and routing
  // ----------------------------------------------------------------
  // One clock source serves every mode; no format setting exists
  acm_mode_t mode_sel;
  logic [2:0] div_val, nch, div_cnt_r, div_cnt_nxt;
  logic samp_r, samp_nxt;
  logic [7:0] route_nxt, route_r;
  logic [3:0] valid_nxt, valid_r;
  logic [31:0] sel_all;

  always_comb begin
    case (mode_r)
      ACM_MODE_DUAL_VAL: begin
        mode_sel = ACM_MODE_DUAL;
        div_val = 3'h2;
        nch = 3'h2;
      end
      ACM_MODE_QUAD_VAL: begin
        mode_sel = ACM_MODE_QUAD;
        div_val = 3'h4;
        nch = 3'h4;
      end
      default: begin
        mode_sel = ACM_MODE_SINGLE;
        div_val = 3'h1;
        nch = 3'h1;
      end
    endcase
  end

  // Divided sample strobe on rising edges; held off in power down
  always_comb begin
    div_cnt_nxt = 3'h0;
    samp_nxt = 1'b0;
    if (!pd_eff) begin
      samp_nxt = (div_cnt_r == div_val - 3'h1);
      div_cnt_nxt = samp_nxt ? 3'h0 : div_cnt_r + 3'h1;
    end
  end

  // Channel one in the high byte of the first register, onward in order
  assign sel_all = {sel12_r, sel34_r};
  generate
    for (gi = 0; gi < 4; gi++) begin : g_route
      logic [7:0] code;
      // Dual mode takes channel two from the second register
      assign code = (gi == 1 && mode_sel == ACM_MODE_DUAL) ? sel34_r[15:8] :
                    sel_all[31 - 8 * gi -: 8];
      always_comb begin
        case (code)
          ACM_IN_ONE: route_nxt[2 * gi +: 2] = 2'h0;
          ACM_IN_TWO: route_nxt[2 * gi +: 2] = 2'h1;
          ACM_IN_THREE: route_nxt[2 * gi +: 2] = 2'h2;
          ACM_IN_FOUR: route_nxt[2 * gi +: 2] = 2'h3;
          default: route_nxt[2 * gi +: 2] = 2'h0;
        endcase
        valid_nxt[gi] = (code == ACM_IN_ONE) || (code == ACM_IN_TWO) ||
                        (code == ACM_IN_THREE) || (code == ACM_IN_FOUR);
        if (3'(gi) >= nch) begin
          valid_nxt[gi] = 1'b0; // Unused channels in this mode
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_r <= 3'h0;
      samp_r <= 1'b0;
      route_r <= 8'h00;
      valid_r <= 4'h0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      samp_r <= samp_nxt;
      route_r <= route_nxt;
      valid_r <= valid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mode_o = mode_sel;
  assign divider_o = div_val;
  assign powered_down_o = pd_eff;
  assign mode_reject_o = reject_r;
  assign sample_en_o = samp_r;
  assign bit_clk_phase_o = phase_r;
  assign ch_input_o = route_r;
  assign ch_valid_o = valid_r;
endmodule : acm_dev
`default_nettype wire

// ===== acm_pkg.sv
// Purpose: Shared constants and types for the converter configuration link.
// Assumes: Serial word of 8 address bits then 16 data bits, MSB first.
// Notes: Both ends import this package whole.
package acm_pkg;
  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int ACM_ADDR_W = 8;
  localparam int ACM_DATA_W = 16;
  localparam int ACM_FRAME_W = 24;
  localparam logic [4:0] ACM_LAST_BIT = 5'h17;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ACM_REG_SOFT_RESET = 8'h00;
  localparam logic [7:0] ACM_REG_POWER = 8'h0f;
  localparam logic [7:0] ACM_REG_MODE = 8'h31;
  localparam logic [7:0] ACM_REG_SEL_12 = 8'h3a;
  localparam logic [7:0] ACM_REG_SEL_34 = 8'h3b;
  localparam logic [7:0] ACM_REG_PHASE = 8'h42;

  // ----------------------------------------------------------------
  // Command values, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ACM_SOFT_RESET_CMD = 16'h0001;
  localparam logic [15:0] ACM_POWER_DOWN_VAL = 16'h0200;
  localparam int ACM_POWER_DOWN_BIT = 9;
  localparam logic [15:0] ACM_MODE_SINGLE_VAL = 16'h0001;
  localparam logic [15:0] ACM_MODE_DUAL_VAL = 16'h0102;
  localparam logic [15:0] ACM_MODE_QUAD_VAL = 16'h0204;
  localparam logic [15:0] ACM_POWER_RST = 16'h0000;
  localparam logic [15:0] ACM_MODE_RST = 16'h0001;
  localparam logic [15:0] ACM_SEL_RST = 16'h0000;
  localparam logic [15:0] ACM_PHASE_RST = 16'h0000;
  localparam logic [7:0] ACM_IN_ONE = 8'h02;
  localparam logic [7:0] ACM_IN_TWO = 8'h04;
  localparam logic [7:0] ACM_IN_THREE = 8'h08;
  localparam logic [7:0] ACM_IN_FOUR = 8'h10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ACM_REF_CLK_MHZ = 20;
  localparam int ACM_RST_PULSE_NS = 400;
  localparam int ACM_RST_PULSE_CYC = (ACM_RST_PULSE_NS * ACM_REF_CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    ACM_MODE_SINGLE,
    ACM_MODE_DUAL,
    ACM_MODE_QUAD
  } acm_mode_t;
endpackage : acm_pkg

// ===== acm_link_if.sv
// Purpose: Pins between the configuration host and the converter.
// Assumes: All lines are one-way; no pin is shared.
// Notes: The host makes the serial clock.
`timescale 1ns/100ps
`default_nettype none
interface acm_link_if;
  // Serial control port
  logic sclk;
  logic cs_n;
  logic sdata;
  // Dedicated pins
  logic chip_reset_low;
  logic power_down_pin;

  modport host (
    output sclk,
    output cs_n,
    output sdata,
    output chip_reset_low,
    output power_down_pin
  );

  modport dev (
    input sclk,
    input cs_n,
    input sdata,
    input chip_reset_low,
    input power_down_pin
  );
endinterface : acm_link_if
`default_nettype wire

// ===== acm_host.sv
// Purpose: Host end: start-up and mode-change sequences over pins and serial link.
// Assumes: Serial clock made here by dividing ref_clk_i.
// Notes: Sends write-only frames, MSB first, data changed on falling link edges.
`timescale 1ns/100ps
`default_nettype none
module acm_host
  import acm_pkg::*;
#(
  parameter int HALF_CYC = 2,
  parameter int RST_CYC = ACM_RST_PULSE_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // User requests
  input wire logic init_req_i,
  input wire logic change_req_i,
  input wire logic [15:0] mode_word_i,
  input wire logic phase_en_i,
  input wire logic [15:0] phase_word_i,
  input wire logic [15:0] sel_a_i,
  input wire logic [15:0] sel_b_i,
  output logic busy_o,
  output logic done_o,
  // Link
  acm_link_if.host link
);
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE, H_RST, H_PD_ON, H_PHASE, H_MODE, H_PD_OFF, H_SEL_A, H_SEL_B
  } acm_hstate_t;
  acm_hstate_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [15:0] mode_r, mode_nxt, phase_r, phase_nxt, sela_r, sela_nxt, selb_r, selb_nxt;
  logic phen_r, phen_nxt, rstp_r, rstp_nxt, pd_r, pd_nxt, done_r, done_nxt;
  logic issued_r, issued_nxt;
  logic go;
  logic [23:0] go_word;
  logic sp_done;

  // Power down is held across the mode write
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    {mode_nxt, phase_nxt, sela_nxt, selb_nxt, phen_nxt} = {mode_r, phase_r, sela_r, selb_r, phen_r};
    rstp_nxt = rstp_r;
    pd_nxt = pd_r;
    done_nxt = 1'b0;
    issued_nxt = issued_r;
    go = 1'b0;
    go_word = {ACM_REG_MODE, mode_r};
    case (st_r)
      H_IDLE: begin
        if (init_req_i || change_req_i) begin
          {mode_nxt, phase_nxt, sela_nxt, selb_nxt} = {mode_word_i, phase_word_i, sel_a_i, sel_b_i};
          phen_nxt = phase_en_i;
          cnt_nxt = 8'h00;
          rstp_nxt = init_req_i;
          pd_nxt = change_req_i;
          st_nxt = init_req_i ? H_RST : H_MODE;
        end
      end
      H_RST: begin
        // Pin held low, then left high for the same time before power down
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == 8'(RST_CYC - 1)) begin
          rstp_nxt = 1'b0;
        end
        if (cnt_r == 8'(2 * RST_CYC - 1)) begin
          st_nxt = H_PD_ON;
        end
      end
      H_PD_ON: begin
        pd_nxt = 1'b1;
        st_nxt = phen_r ? H_PHASE : H_MODE;
      end
      H_PHASE, H_MODE, H_SEL_A, H_SEL_B: begin
        case (st_r)
          H_PHASE: go_word = {ACM_REG_PHASE, phase_r};
          H_SEL_A: go_word = {ACM_REG_SEL_12, sela_r};
          H_SEL_B: go_word = {ACM_REG_SEL_34, selb_r};
          default: go_word = {ACM_REG_MODE, mode_r};
        endcase
        go = !issued_r;
        issued_nxt = 1'b1;
        if (sp_done) begin
          issued_nxt = 1'b0;
          case (st_r)
            H_PHASE: st_nxt = H_MODE;
            H_MODE: st_nxt = H_PD_OFF;
            H_SEL_A: st_nxt = H_SEL_B;
            default: begin
              st_nxt = H_IDLE;
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      H_PD_OFF: begin
        pd_nxt = 1'b0;
        st_nxt = H_SEL_A;
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= H_IDLE;
      cnt_r <= 8'h00;
      {mode_r, phase_r, sela_r, selb_r, phen_r} <= 65'h0;
      {rstp_r, pd_r, done_r, issued_r} <= 4'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      {mode_r, phase_r, sela_r, selb_r, phen_r} <= {mode_nxt, phase_nxt, sela_nxt, selb_nxt, phen_nxt};
      {rstp_r, pd_r, done_r, issued_r} <= {rstp_nxt, pd_nxt, done_nxt, issued_nxt};
    end
  end

  // ----------------------------------------------------------------
  // Serial engine: divided clock, idle low outside frames
  // ----------------------------------------------------------------
  logic sp_busy_r, sp_busy_nxt, sclk_r, sclk_nxt, csn_r, csn_nxt, tail_r, tail_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [7:0] div_r, div_nxt;
  logic [23:0] sh_r, sh_nxt;

  always_comb begin
    {sp_busy_nxt, sclk_nxt, csn_nxt, tail_nxt} = {sp_busy_r, sclk_r, csn_r, tail_r};
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    sp_done = 1'b0;
    div_nxt = (div_r == 8'(HALF_CYC - 1)) ? 8'h00 : div_r + 8'h01;
    if (!sp_busy_r) begin
      div_nxt = 8'h00;
      if (go) begin
        {sp_busy_nxt, csn_nxt, tail_nxt} = 3'b100;
        sh_nxt = go_word;
        bit_nxt = 5'h00;
      end
    end else if (div_r == 8'(HALF_CYC - 1)) begin
      if (tail_r) begin
        {sp_busy_nxt, tail_nxt} = 2'b00;
        sp_done = 1'b1;
      end else if (!sclk_r) begin
        sclk_nxt = 1'b1;
      end else begin
        sclk_nxt = 1'b0;
        sh_nxt = {sh_r[22:0], 1'b0};
        bit_nxt = bit_r + 5'h01;
        if (bit_r == ACM_LAST_BIT) begin
          {csn_nxt, tail_nxt} = 2'b11;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {sp_busy_r, sclk_r, csn_r, tail_r} <= 4'b0010;
      bit_r <= 5'h00;
      div_r <= 8'h00;
      sh_r <= 24'h000000;
    end else begin
      {sp_busy_r, sclk_r, csn_r, tail_r} <= {sp_busy_nxt, sclk_nxt, csn_nxt, tail_nxt};
      bit_r <= bit_nxt;
      div_r <= div_nxt;
      sh_r <= sh_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.sclk = sclk_r;
  assign link.cs_n = csn_r;
  assign link.sdata = sh_r[23];
  assign link.chip_reset_low = !rstp_r;
  assign link.power_down_pin = pd_r;
  assign busy_o = (st_r != H_IDLE);
  assign done_o = done_r;
endmodule : acm_host
`default_nettype wire

// ===== acm_link_assertions.sv
// Purpose: Protocol checks on the link between host and converter ends.
// Assumes: Host built with HALF_CYC 2 and RST_CYC 8.
// Notes: Link pins are sampled on ref_clk_i, which also makes the link clock.
`timescale 1ns/100ps
`default_nettype none
module acm_link_assertions
  import acm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdata,
  input wire logic chip_reset_low,
  input wire logic power_down_pin
);
  // ---------------------------------------------
  // Frame capture
  // ---------------------------------------------
  logic sclk_r, sclk_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] sh_r, sh_nxt;
  // Shift on each rising link clock inside a frame; the bit count clears between frames, the shift register holds
  always_comb begin
    sclk_nxt = sclk;
    cnt_nxt = cs_n ? 5'h00 : cnt_r;
    sh_nxt = sh_r;
    if (!cs_n && sclk && !sclk_r) begin
      cnt_nxt = cnt_r + 5'h01;
      sh_nxt = {sh_r[22:0], sdata};
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_r <= 1'b0;
      cnt_r <= 5'h00;
      sh_r <= 24'h000000;
    end else begin
      sclk_r <= sclk_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
    end
  end
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_clk_idle_low: assert property (cs_n |-> !sclk)
    else $error("link clock active outside frame");
  chk_data_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(sdata)
    |-> $fell(sclk)) else $error("data moved off a falling link edge");
  chk_frame_whole: assert property ($rose(cs_n) |-> cnt_r == 5'h18)
    else $error("frame not 24 bits");
  chk_frame_gap: assert property ($rose(cs_n) |-> cs_n[*2])
    else $error("frames too close");
  chk_mode_in_pd: assert property ($rose(cs_n) && sh_r[23:16] == ACM_REG_MODE
    |-> power_down_pin) else $error("mode written while active");
  chk_sel_active: assert property ($rose(cs_n) && sh_r[23:16] == ACM_REG_SEL_12 |-> !power_down_pin)
    else $error("input select while powered down");
  chk_reset_pulse: assert property ($fell(chip_reset_low) |-> !chip_reset_low[*8]
    ##1 chip_reset_low) else $error("reset pulse length wrong");
  chk_pd_after_rst: assert property ($rose(chip_reset_low) |->
    (cs_n && !power_down_pin)[*7] ##[1:3] power_down_pin)
    else $error("no power down after reset");
  chk_quiet_in_rst: assert property (!chip_reset_low |-> cs_n)
    else $error("frame during reset pulse");
  // Main scenarios
  cov_mode_frame: cover property ($rose(cs_n) && sh_r[23:16] == ACM_REG_MODE);
  cov_sel_frame: cover property ($rose(cs_n) && sh_r[23:16] == ACM_REG_SEL_34);
  cov_reset_pin: cover property ($rose(chip_reset_low));
endmodule : acm_link_assertions
`default_nettype wire

// ===== testbench.sv
// Purpose: Drives host requests and judges the converter end's outputs.
// Assumes: Host HALF_CYC 2, RST_CYC 8; link clock made by the host.
// Notes: Dual mode checks both channels; channel two comes from the second register.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import acm_pkg::*;
  // ---------------------------------------------
  // Signals and instances
  // ---------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic init_req_i = 1'b0;
  logic change_req_i = 1'b0;
  logic [15:0] mode_word_i = 16'h0000;
  logic phase_en_i = 1'b0;
  logic [15:0] phase_word_i = 16'h0000;
  logic [15:0] sel_a_i = 16'h0000;
  logic [15:0] sel_b_i = 16'h0000;
  logic busy_o, done_o, saw_pd;
  logic [1:0] mode_o;
  logic [2:0] divider_o;
  logic powered_down_o, mode_reject_o, sample_en_o;
  logic [15:0] bit_clk_phase_o;
  logic [7:0] ch_input_o;
  logic [3:0] ch_valid_o;
  int errors = 0;
  int num_checks = 0;
  acm_link_if link ();
  acm_host #(.HALF_CYC(2), .RST_CYC(8)) acm_host_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .init_req_i(init_req_i), .change_req_i(change_req_i),
    .mode_word_i(mode_word_i), .phase_en_i(phase_en_i), .phase_word_i(phase_word_i),
    .sel_a_i(sel_a_i), .sel_b_i(sel_b_i), .busy_o(busy_o), .done_o(done_o), .link(link));
  acm_dev acm_dev_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link),
    .mode_o(mode_o), .divider_o(divider_o), .powered_down_o(powered_down_o),
    .mode_reject_o(mode_reject_o), .sample_en_o(sample_en_o),
    .bit_clk_phase_o(bit_clk_phase_o), .ch_input_o(ch_input_o), .ch_valid_o(ch_valid_o));
  acm_link_assertions acm_link_assertions_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .sclk(link.sclk), .cs_n(link.cs_n), .sdata(link.sdata),
    .chip_reset_low(link.chip_reset_low), .power_down_pin(link.power_down_pin));
  // 50 ns sample clock
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic report_and_stop();
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One host sequence; bounded wait for done, then settle time for the device
  task automatic run(input logic init, input logic [15:0] mw, sa, sb);
    int i;
    saw_pd = 1'b0;
    @(posedge ref_clk_i);
    init_req_i <= init;
    change_req_i <= !init;
    mode_word_i <= mw;
    sel_a_i <= sa;
    sel_b_i <= sb;
    @(posedge ref_clk_i);
    init_req_i <= 1'b0;
    change_req_i <= 1'b0;
    @(negedge ref_clk_i);
    check(16'(busy_o), 16'h0001);
    for (i = 0; i < 3000 && done_o !== 1'b1; i++) begin
      @(negedge ref_clk_i);
      if (powered_down_o === 1'b1) saw_pd = 1'b1;
    end
    if (i == 3000) begin
      errors++;
      report_and_stop();
    end
    check(16'(busy_o), 16'h0000);
    repeat (10) @(negedge ref_clk_i);
  endtask : run
  // Mode outputs plus sample rate counted over 32 clocks
  task automatic expect_mode(input logic [1:0] m, input logic [2:0] d,
                             input logic [7:0] inp, msk, input logic [3:0] v);
    int n;
    n = 0;
    check(16'(mode_o), 16'(m));
    check(16'(divider_o), 16'(d));
    check(16'(ch_input_o & msk), 16'(inp));
    check(16'(ch_valid_o), 16'(v));
    check(16'(powered_down_o), 16'h0000);
    repeat (32) begin
      @(negedge ref_clk_i);
      if (sample_en_o === 1'b1) n++;
    end
    check(16'(n), 16'(32 / d));
  endtask : expect_mode
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic sc_defaults();
    @(negedge ref_clk_i);
    check(16'(mode_o), 16'h0000);
    check(16'(divider_o), 16'h0001);
    check(16'(ch_valid_o), 16'h0000);
    check(bit_clk_phase_o, ACM_PHASE_RST);
    check(16'(mode_reject_o), 16'h0000);
  endtask : sc_defaults
  task automatic sc_init_dual();
    @(posedge ref_clk_i);
    phase_en_i <= 1'b1;
    phase_word_i <= 16'h0005;
    run(1'b1, ACM_MODE_DUAL_VAL, 16'h0202, 16'h0808);
    check(16'(saw_pd), 16'h0001);
    check(bit_clk_phase_o, 16'h0005);
    expect_mode(2'h1, 3'h2, 8'h08, 8'h0f, 4'h3);
  endtask : sc_init_dual
  // Quad and single through the change sequence, with no clock format setting
  task automatic sc_modes();
    run(1'b0, ACM_MODE_QUAD_VAL, 16'h1008, 16'h0402);
    check(16'(saw_pd), 16'h0001);
    expect_mode(2'h2, 3'h4, 8'h1b, 8'hff, 4'hf);
    run(1'b0, ACM_MODE_SINGLE_VAL, 16'h1010, 16'h1010);
    expect_mode(2'h0, 3'h1, 8'h03, 8'h03, 4'h1);
    run(1'b0, ACM_MODE_SINGLE_VAL, 16'h0202, 16'h0202);
    expect_mode(2'h0, 3'h1, 8'h00, 8'h03, 4'h1);
  endtask : sc_modes
  // Bad code refused and flagged, dual kept; a good write clears the flag
  task automatic sc_bad_mode();
    run(1'b0, 16'h0303, 16'h0202, 16'h0202);
    check(16'(mode_reject_o), 16'h0001);
    check(16'(mode_o), 16'h0001);
    run(1'b0, ACM_MODE_DUAL_VAL, 16'h0202, 16'h0808);
    check(16'(mode_reject_o), 16'h0000);
    expect_mode(2'h1, 3'h2, 8'h08, 8'h0f, 4'h3);
  endtask : sc_bad_mode
  // Second reset in mid-run reloads defaults
  task automatic sc_reset_mid();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    sc_defaults();
  endtask : sc_reset_mid
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    sc_defaults();
    sc_init_dual();
    sc_bad_mode();
    sc_modes();
    sc_reset_mid();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
